// ==== pkg/bsf_pkg.sv ====
// Constants, opcodes and carrier types for the special-function slice.
// Assumes one 125 MHz clock and a microword register on the same clock.
// Operation
// - Low opcode field all zero selects special mode; upper field picks the function.
// - Single normalize shifts queue up each edge, low port feeding its bottom bit.
// - Top slice carry-out is queue bit three XOR bit two.
// - Top slice overflow is queue bit two XOR bit one, one cycle early.
// - Single normalize releases the zero line high when the queue is zero.
// - Single normalize sign output is the queue top bit on the top slice.
// - Single normalize writes B plus carry-in back to B to count shifts.
// - Double normalize shifts B register over queue as one long word.
// - Double normalize top flags come from the ALU output, not queue.
// - Double normalize zero line high only if ALU output and queue are zero.
// - Conversion takes operand on S; top slice puts its sign on zero line.
// - Converting one-followed-by-zeros to sign/magnitude raises overflow.
// - Sign/magnitude negative zero converts to all zeros.
// - Increment adds one with carry-in low, two with carry-in high.
// - During multiply only the least slice drives the zero line.
// - Least slice zero output equals queue bit zero during multiply.
// - Zero line high adds multiplicand to partial product; low passes it.
// - Multiply stores ALU result shifted down into the B register.
// - Unsigned multiply shifts top slice carry-out into its top result bit.
// - Multiplier bits move down between queue ports; integrator closes ALU-queue loop.
// - After sixteen steps high product is in B, low product in queue.
// - Signed multiply shifts sign XOR overflow into the top result bit.
// - After fifteen signed steps the least slice zero output is multiplier sign.
// - Last-cycle command subtracts multiplicand when multiplier sign is negative.
package bsf_pkg;
  localparam int SLICE_W   = 4;
  localparam int ADDR_W    = 4;
  localparam int RAM_DEPTH = 16;
  localparam int LOW_W     = 5;
  localparam int FUNC_W    = 4;
  localparam int BIT_MSB   = 3;
  localparam int BIT_NXT   = 2;
  localparam int BIT_THD   = 1;
  localparam int BIT_LSB   = 0;

  localparam logic [LOW_W-1:0]   LOW_SPECIAL = 5'h00;
  localparam logic [FUNC_W-1:0]  FN_UMUL     = 4'h0;
  localparam logic [FUNC_W-1:0]  FN_TCMUL    = 4'h2;
  localparam logic [FUNC_W-1:0]  FN_INC      = 4'h4;
  localparam logic [FUNC_W-1:0]  FN_CONV     = 4'h5;
  localparam logic [FUNC_W-1:0]  FN_TCLAST   = 4'h6;
  localparam logic [FUNC_W-1:0]  FN_SNORM    = 4'h8;
  localparam logic [FUNC_W-1:0]  FN_DNORM    = 4'hA;
  localparam logic [SLICE_W-1:0] WORD_ZERO   = 4'h0;
  localparam logic [SLICE_W-1:0] WORD_ONE    = 4'h1;
  localparam logic [SLICE_W-1:0] Q_RESET     = 4'h0;

  typedef struct packed {
    logic [FUNC_W-1:0] func;
    logic [LOW_W-1:0]  low;
    logic [ADDR_W-1:0] a_addr;
    logic [ADDR_W-1:0] b_addr;
    logic              cn;
  } bsf_ucode_t;

  typedef struct packed {
    logic cn4;
    logic overflow_flag_out;
    logic sign;
  } bsf_flags_t;
endpackage

// ==== verilog/bsf_adder.sv ====
// Four-bit adder of the slice with carry, overflow and carry into the top bit.
// Assumes operands are already selected and complemented by the caller.
`timescale 1ns/1ps
module bsf_adder
  import bsf_pkg::*;
(
  // Operands
  input  wire logic [SLICE_W-1:0] r_in,
  input  wire logic [SLICE_W-1:0] s_in,
  input  wire logic               c_in,
  // Results
  output logic      [SLICE_W-1:0] sum,
  output logic                    c_msb,
  output logic                    c_out,
  output logic                    overflow_flag_out
);
  logic [SLICE_W-1:0] low_sum;
  logic [1:0]         top_sum;

  // Split at the top bit so the carry into it is visible for overflow
  assign low_sum = {1'b0, r_in[BIT_MSB-1:0]} + {1'b0, s_in[BIT_MSB-1:0]}
                   + {3'h0, c_in};
  assign c_msb   = low_sum[BIT_MSB];
  assign top_sum = {1'b0, r_in[BIT_MSB]} + {1'b0, s_in[BIT_MSB]} + {1'b0, c_msb};
  assign sum     = {top_sum[0], low_sum[BIT_MSB-1:0]};
  assign c_out   = top_sum[1];
  assign overflow_flag_out     = c_out ^ c_msb;
endmodule

// ==== verilog/bsf_slice.sv ====
// One cascadable four-bit slice: RAM, queue register and special functions.
// Assumes neighbours and the microword register run on clk_sys; straps are static.
`timescale 1ns/1ps
module bsf_slice
  import bsf_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  // Microword
  input  wire bsf_ucode_t         ucode,
  // Cascade straps
  input  wire logic               lss_n,
  input  wire logic               top_slice,
  // Shared zero line, open drain
  input  wire logic               z_in,
  output logic                    z_out,
  output logic                    z_oe_n,
  // Queue shift ports
  input  wire logic               queue_low_shift_port_in,
  output logic                    queue_low_shift_port_out,
  output logic                    queue_low_shift_port_oe_n,
  input  wire logic               queue_high_shift_port_in,
  output logic                    queue_high_shift_port_out,
  output logic                    queue_high_shift_port_oe_n,
  // ALU shift ports
  input  wire logic               alu_low_shift_port_in,
  output logic                    alu_low_shift_port_out,
  output logic                    alu_low_shift_port_oe_n,
  input  wire logic               alu_high_shift_port_in,
  output logic                    alu_high_shift_port_out,
  output logic                    alu_high_shift_port_oe_n,
  // Result and flags
  output logic      [SLICE_W-1:0] y,
  output bsf_flags_t              flags
);
  logic               rst_meta_reg;
  logic               rst_sync_reg;
  logic [SLICE_W-1:0] ram_mem [RAM_DEPTH];
  logic [SLICE_W-1:0] q_reg;
  logic [SLICE_W-1:0] q_next;
  logic [SLICE_W-1:0] a_val;
  logic [SLICE_W-1:0] b_val;
  logic [SLICE_W-1:0] r_op;
  logic [SLICE_W-1:0] s_op;
  logic               c_op;
  logic [SLICE_W-1:0] sum;
  logic               c_msb;
  logic               c_out;
  logic               add_ovr;
  logic [SLICE_W-1:0] f_val;
  logic [SLICE_W-1:0] wr_next;
  logic               wr_en;
  logic               top_shin;
  logic               special;
  logic               is_snorm;
  logic               is_dnorm;
  logic               is_conv;
  logic               is_inc;
  logic               is_umul;
  logic               is_tcmul;
  logic               is_tclast;
  logic               is_mul;
  logic               is_lss;
  logic               neg;

  function automatic logic is_zero(input logic [SLICE_W-1:0] w);
    is_zero = (w == WORD_ZERO);
  endfunction

  function automatic logic fn_hit(input bsf_ucode_t u, input logic [FUNC_W-1:0] code);
    fn_hit = (u.low == LOW_SPECIAL) && (u.func == code);
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Function decode
  assign special   = (ucode.low == LOW_SPECIAL);
  assign is_snorm  = fn_hit(ucode, FN_SNORM);
  assign is_dnorm  = fn_hit(ucode, FN_DNORM);
  assign is_conv   = fn_hit(ucode, FN_CONV);
  assign is_inc    = fn_hit(ucode, FN_INC);
  assign is_umul   = fn_hit(ucode, FN_UMUL);
  assign is_tcmul  = fn_hit(ucode, FN_TCMUL);
  assign is_tclast = fn_hit(ucode, FN_TCLAST);
  assign is_mul    = is_umul || is_tcmul || is_tclast;
  assign is_lss    = !lss_n;
  assign neg       = z_in;

  // Two read ports of the register file
  assign a_val = ram_mem[ucode.a_addr];
  assign b_val = ram_mem[ucode.b_addr];

  // Operand selection
  always_comb begin
    r_op = WORD_ZERO;
    s_op = b_val;
    c_op = ucode.cn;
    if (is_snorm) begin
      c_op = ucode.cn;
    end else if (is_dnorm) begin
      c_op = 1'b0;
    end else if (is_conv) begin
      // Negative operand: invert and take the +1 rippled in on carry
      s_op = neg ? ~b_val : b_val;
      c_op = neg ? ucode.cn : 1'b0;
    end else if (is_inc) begin
      r_op = is_lss ? WORD_ONE : WORD_ZERO;
    end else if (is_umul || is_tcmul) begin
      r_op = z_in ? a_val : WORD_ZERO;
    end else if (is_tclast) begin
      // Subtract as B + ~A + 1; the +1 enters only at the least slice
      r_op = z_in ? ~a_val : WORD_ZERO;
      c_op = is_lss ? z_in : ucode.cn;
    end
  end

  bsf_adder u_adder (
    .r_in  (r_op),
    .s_in  (s_op),
    .c_in  (c_op),
    .sum   (sum),
    .c_msb (c_msb),
    .c_out (c_out),
    .overflow_flag_out   (add_ovr)
  );

  // Top bit fix-up for conversion: minus zero folds to zero
  always_comb begin
    f_val = sum;
    if (is_conv && top_slice && neg) begin
      f_val[BIT_MSB] = ~sum[BIT_MSB];
    end
  end

  // Bit shifted into the top of a down shift
  always_comb begin
    if (!top_slice) begin
      top_shin = alu_high_shift_port_in;
    end else if (is_umul) begin
      top_shin = c_out;
    end else begin
      top_shin = f_val[BIT_MSB] ^ add_ovr;
    end
  end

  // Write-back value and enable
  always_comb begin
    wr_next = f_val;
    if (is_dnorm) begin
      // ALU passes B here; taking B bitwise keeps unwritten RAM bits from smearing
      wr_next = {b_val[BIT_MSB-1:0], alu_low_shift_port_in};
    end else if (is_mul) begin
      wr_next = {top_shin, f_val[BIT_MSB:BIT_THD]};
    end
  end
  assign wr_en = rst_sync_reg && (is_snorm || is_dnorm || is_conv || is_inc || is_mul);

  // No reset on the register file, as in the original storage
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      ram_mem[ucode.b_addr] <= wr_next;
    end
  end

  // Queue register
  always_comb begin
    q_next = q_reg;
    if (is_snorm || is_dnorm) begin
      q_next = {q_reg[BIT_MSB-1:0], queue_low_shift_port_in};
    end else if (is_mul) begin
      q_next = {queue_high_shift_port_in, q_reg[BIT_MSB:BIT_THD]};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= Q_RESET;
    end else if (rst_sync_reg) begin
      q_reg <= q_next;
    end
  end

  // Shift port drivers; oe_n low while driving
  assign queue_low_shift_port_out   = q_reg[BIT_LSB];
  assign queue_low_shift_port_oe_n  = !is_mul;
  assign queue_high_shift_port_out  = q_reg[BIT_MSB];
  assign queue_high_shift_port_oe_n = !(is_snorm || is_dnorm);
  assign alu_low_shift_port_out     = f_val[BIT_LSB];
  assign alu_low_shift_port_oe_n    = !is_mul;
  assign alu_high_shift_port_out    = f_val[BIT_MSB];
  assign alu_high_shift_port_oe_n   = !is_dnorm;

  // Zero line: only ever pulled low, so the wired level is an AND
  assign z_out = 1'b0;
  always_comb begin
    if (is_snorm) begin
      z_oe_n = is_zero(q_reg);
    end else if (is_dnorm) begin
      z_oe_n = is_zero(f_val) && is_zero(q_reg);
    end else if (is_conv) begin
      z_oe_n = top_slice ? b_val[BIT_MSB] : 1'b1;
    end else if (is_mul) begin
      z_oe_n = is_lss ? q_reg[BIT_LSB] : 1'b1;
    end else begin
      z_oe_n = is_zero(f_val);
    end
  end

  // Flags are combinational so the normalize test sees this cycle's queue
  always_comb begin
    flags.cn4  = c_out;
    flags.overflow_flag_out  = add_ovr;
    flags.sign = f_val[BIT_MSB];
    if (top_slice && is_snorm) begin
      flags.cn4  = q_reg[BIT_MSB] ^ q_reg[BIT_NXT];
      flags.overflow_flag_out  = q_reg[BIT_NXT] ^ q_reg[BIT_THD];
      flags.sign = q_reg[BIT_MSB];
    end else if (top_slice && is_dnorm) begin
      flags.cn4  = f_val[BIT_MSB] ^ f_val[BIT_NXT];
      flags.overflow_flag_out  = f_val[BIT_NXT] ^ f_val[BIT_THD];
      flags.sign = f_val[BIT_MSB];
    end else if (top_slice && is_conv) begin
      flags.overflow_flag_out  = neg && sum[BIT_MSB];
    end
  end

  assign y = wr_next;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_sync_reg);

  sequence s_snorm;
    is_snorm;
  endsequence

  sequence s_mul_step;
    is_mul && wr_en;
  endsequence

  property p_snorm_shift;
    s_snorm |=> q_reg == $past({q_reg[BIT_MSB-1:0], queue_low_shift_port_in});
  endproperty
  a_snorm_shift: assert property (p_snorm_shift)
    else $error("queue did not shift up on single normalize");

  property p_norm_done;
    (s_snorm and top_slice) |-> flags.cn4 == (q_reg[BIT_MSB] != q_reg[BIT_NXT]);
  endproperty
  a_norm_done: assert property (p_norm_done)
    else $error("normalize carry-out wrong");

  property p_norm_early;
    (s_snorm and (top_slice && flags.overflow_flag_out && !flags.cn4))
      |=> !is_snorm || flags.cn4;
  endproperty
  a_norm_early: assert property (p_norm_early)
    else $error("early normalize indication not followed by carry-out");

  property p_snorm_zero;
    s_snorm |-> z_oe_n == (q_reg == WORD_ZERO);
  endproperty
  a_snorm_zero: assert property (p_snorm_zero)
    else $error("zero line wrong during single normalize");

  property p_snorm_count;
    s_snorm |-> y == 4'(b_val + {3'h0, ucode.cn});
  endproperty
  a_snorm_count: assert property (p_snorm_count)
    else $error("shift count not B plus carry");

  property p_dnorm_zero;
    is_dnorm && !z_oe_n |-> (f_val != WORD_ZERO) || (q_reg != WORD_ZERO);
  endproperty
  a_dnorm_zero: assert property (p_dnorm_zero)
    else $error("double normalize zero line pulled with zero word");

  property p_conv_minneg;
    is_conv && top_slice && neg && b_val[BIT_MSB-1:0] == 3'h0 && ucode.cn
      |-> flags.overflow_flag_out && y[BIT_MSB] == 1'b0;
  endproperty
  a_conv_minneg: assert property (p_conv_minneg)
    else $error("most negative conversion did not flag overflow");

  property p_inc;
    is_inc && is_lss |-> y == 4'(b_val + WORD_ONE + {3'h0, ucode.cn});
  endproperty
  a_inc: assert property (p_inc)
    else $error("increment amount wrong");

  property p_mul_z;
    (s_mul_step and is_lss)
      |-> z_oe_n == q_reg[BIT_LSB] && queue_low_shift_port_oe_n == 1'b0;
  endproperty
  a_mul_z: assert property (p_mul_z)
    else $error("least slice zero output is not multiplier bit");

  property p_mul_store;
    s_mul_step ##1 1'b1 |-> ram_mem[$past(ucode.b_addr)] == $past(wr_next)
      && q_reg == $past({queue_high_shift_port_in, q_reg[BIT_MSB:BIT_THD]});
  endproperty
  a_mul_store: assert property (p_mul_store)
    else $error("multiply step did not store shifted result");

  property p_umul_carry;
    is_umul && top_slice |-> y[BIT_MSB] == c_out;
  endproperty
  a_umul_carry: assert property (p_umul_carry)
    else $error("unsigned multiply top bit is not carry-out");
endmodule

// ==== verification/bsf_far_model.sv ====
// Far side of one slice: microword pipeline register, zero line and shift links.
// Assumes a single slice strapped as both least and top slice.
`timescale 1ns/1ps
module bsf_far_model
  import bsf_pkg::*;
(
  // Bench side
  input  wire logic       clk_sys,
  input  wire bsf_ucode_t ucode_d,
  input  wire logic       ld_bit,
  // Slice side
  output bsf_ucode_t      ucode,
  input  wire logic       z_oe_n,
  output logic            z_line,
  input  wire logic       queue_high_out,
  input  wire logic       alu_low_out,
  output logic            queue_low_in,
  output logic            queue_high_in,
  output logic            alu_low_in,
  output logic            alu_high_in
);
  bsf_ucode_t u_reg;
  logic       ld_reg;
  logic       tgl_reg = 1'h0;
  logic       sp;
  // Word fetched in one cycle executes in the next
  always_ff @(posedge clk_sys) begin
    u_reg   <= ucode_d;
    ld_reg  <= ld_bit;
    tgl_reg <= ~tgl_reg;
  end
  assign sp = (u_reg.low == LOW_SPECIAL);
  // Pull-up: high unless some slice pulls low
  assign z_line = z_oe_n ? 1'h1 : 1'h0;
  // Conversion ties lowest carry-in to the zero line
  always_comb begin
    ucode = u_reg;
    if (sp && u_reg.func == FN_CONV) begin
      ucode.cn = z_line;
    end
  end
  // Unused links toggle so a stale level never passes as a drive
  assign queue_high_in = (sp && u_reg.func inside {FN_UMUL, FN_TCMUL, FN_TCLAST})
                         ? alu_low_out : tgl_reg;
  assign alu_low_in    = (sp && u_reg.func == FN_DNORM) ? queue_high_out : tgl_reg;
  assign queue_low_in  = (sp && u_reg.func == FN_DNORM) ? ld_reg
                         : (sp && u_reg.func == FN_SNORM) ? 1'h0 : tgl_reg;
  assign alu_high_in   = tgl_reg;
endmodule

// ==== verification/bsf_slice_tb_top.sv ====
// Self-checking bench for one special-function slice and its far-side model.
// Assumes one slice strapped as least and top; values enter by shifting.
`timescale 1ns/1ps
module bsf_slice_tb_top
  import bsf_pkg::*;
;
  typedef struct packed {
    logic [3:0] fn;
    logic       cn;
    logic [3:0] b;
    logic [3:0] q;
    logic [3:0] ey;
    logic       ym;
    logic [2:0] ef;
    logic [2:0] fm;
    logic       ez;
  } bsf_row_t;
  localparam bsf_row_t ROWS [12] = '{
    '{FN_SNORM, 1'h0, 4'h5, 4'h6, 4'h5, 1'h1, 3'h4, 3'h7, 1'h0},
    '{FN_SNORM, 1'h1, 4'h5, 4'h0, 4'h6, 1'h1, 3'h0, 3'h7, 1'h1},
    '{FN_SNORM, 1'h1, 4'hF, 4'hB, 4'h0, 1'h1, 3'h7, 3'h7, 1'h0},
    '{FN_DNORM, 1'h0, 4'h0, 4'h0, 4'h0, 1'h0, 3'h0, 3'h7, 1'h1},
    '{FN_DNORM, 1'h0, 4'h0, 4'h1, 4'h0, 1'h0, 3'h0, 3'h7, 1'h0},
    '{FN_DNORM, 1'h0, 4'h4, 4'h0, 4'h0, 1'h0, 3'h6, 3'h7, 1'h0},
    '{FN_INC,   1'h0, 4'h7, 4'h0, 4'h8, 1'h1, 3'h0, 3'h0, 1'hX},
    '{FN_INC,   1'h1, 4'h7, 4'h0, 4'h9, 1'h1, 3'h0, 3'h0, 1'hX},
    '{FN_INC,   1'h1, 4'hF, 4'h0, 4'h1, 1'h1, 3'h0, 3'h0, 1'hX},
    '{FN_CONV,  1'h0, 4'h5, 4'h0, 4'h5, 1'h1, 3'h0, 3'h0, 1'h0},
    '{FN_CONV,  1'h0, 4'hD, 4'h0, 4'hB, 1'h1, 3'h0, 3'h0, 1'h1},
    '{FN_CONV,  1'h0, 4'h8, 4'h0, 4'h0, 1'h1, 3'h2, 3'h2, 1'h1}
  };
  logic       clk_sys;
  logic       arst_n;
  bsf_ucode_t ucode_d;
  bsf_ucode_t ucode;
  logic       ld_bit;
  logic       z_oe_n;
  logic       z_line;
  logic       qlo_in;
  logic       qhi_in;
  logic       qhi_out;
  logic       alo_in;
  logic       alo_out;
  logic       ahi_in;
  logic [3:0] y;
  bsf_flags_t flags;
  logic [3:0] hi;
  int         err_count = 0;
  int         comparisons = 0;

  bsf_slice i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .ucode(ucode), .lss_n(1'h0), .top_slice(1'h1),
    .z_in(z_line), .z_out(), .z_oe_n(z_oe_n),
    .queue_low_shift_port_in(qlo_in), .queue_low_shift_port_out(),
    .queue_low_shift_port_oe_n(), .queue_high_shift_port_in(qhi_in),
    .queue_high_shift_port_out(qhi_out), .queue_high_shift_port_oe_n(),
    .alu_low_shift_port_in(alo_in), .alu_low_shift_port_out(alo_out),
    .alu_low_shift_port_oe_n(), .alu_high_shift_port_in(ahi_in),
    .alu_high_shift_port_out(), .alu_high_shift_port_oe_n(), .y(y), .flags(flags)
  );
  bsf_far_model i_far (
    .clk_sys(clk_sys), .ucode_d(ucode_d), .ld_bit(ld_bit), .ucode(ucode),
    .z_oe_n(z_oe_n), .z_line(z_line), .queue_high_out(qhi_out), .alu_low_out(alo_out),
    .queue_low_in(qlo_in), .queue_high_in(qhi_in), .alu_low_in(alo_in),
    .alu_high_in(ahi_in)
  );

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [3:0] fn, input logic [4:0] low, input logic [3:0] a,
                     input logic [3:0] b, input logic cn, input logic ld);
    @(posedge clk_sys);
    ucode_d <= '{fn, low, a, b, cn};
    ld_bit  <= ld;
  endtask

  // Park an idle word behind the last op, then see that op's outputs
  task automatic look(input logic [3:0] b);
    put(FN_INC, 5'h01, 4'h0, b, 1'h0, 1'h0);
    @(negedge clk_sys);
  endtask

  // No load path: shift the value in through the double-length word
  task automatic load(input logic [3:0] b, input logic [7:0] w);
    for (int i = 7; i >= 0; i--) put(FN_DNORM, 5'h00, 4'h0, b, 1'h0, w[i]);
  endtask

  task automatic mul(input logic [3:0] fa, input logic [3:0] fl, input logic [3:0] a,
                     input logic [3:0] m, input logic [7:0] p);
    load(4'h1, {a, 4'h0});
    load(4'h0, {4'h0, m});
    for (int i = 0; i < 4; i++) put((i == 3) ? fl : fa, 5'h00, 4'h1, 4'h0, 1'h0, 1'h0);
    look(4'h0);
    chk({7'h00, z_line}, {7'h00, m[3]});
    look(4'h0);
    hi = y;
    repeat (4) put(FN_DNORM, 5'h00, 4'h0, 4'h0, 1'h0, 1'h0);
    look(4'h0);
    look(4'h0);
    chk({hi, y}, p);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end

  initial begin
    arst_n  = 1'h0;
    ld_bit  = 1'h0;
    ucode_d = '{FN_INC, 5'h01, 4'h0, 4'h0, 1'h0};
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk_sys);
    load(4'h3, 8'h00);
    put(FN_SNORM, 5'h00, 4'h0, 4'h3, 1'h0, 1'h0);
    look(4'h3);
    chk({5'h00, flags}, 8'h00);
    chk({4'h0, y}, 8'h00);
    chk({7'h00, z_line}, 8'h01);
    foreach (ROWS[i]) begin
      load(4'h2, {ROWS[i].b, ROWS[i].q});
      put(ROWS[i].fn, 5'h00, 4'h2, 4'h2, ROWS[i].cn, 1'h0);
      look(4'h2);
      if (ROWS[i].ym) chk({4'h0, y}, {4'h0, ROWS[i].ey});
      chk({5'h00, flags & ROWS[i].fm}, {5'h00, ROWS[i].ef});
      if (ROWS[i].ez !== 1'hX) chk({7'h00, z_line}, {7'h00, ROWS[i].ez});
      look(4'h2);
      if (ROWS[i].ym) chk({4'h0, y}, {4'h0, ROWS[i].ey});
    end
    // Back-to-back normalize steps: queue moves up, B counts shifts
    load(4'h2, 8'h03);
    repeat (3) put(FN_SNORM, 5'h00, 4'h0, 4'h2, 1'h1, 1'h0);
    look(4'h2);
    chk({5'h00, flags}, 8'h03);
    look(4'h2);
    chk({4'h0, y}, 8'h03);
    // Nonzero low field: no write
    load(4'h3, 8'h60);
    put(FN_INC, 5'h02, 4'h0, 4'h3, 1'h1, 1'h0);
    look(4'h3);
    look(4'h3);
    chk({4'h0, y}, 8'h06);
    mul(FN_UMUL, FN_UMUL, 4'hF, 4'hF, 8'hE1);
    mul(FN_UMUL, FN_UMUL, 4'hB, 4'h6, 8'h42);
    mul(FN_TCMUL, FN_TCLAST, 4'hD, 4'h5, 8'hF1);
    mul(FN_TCMUL, FN_TCLAST, 4'h3, 4'hB, 8'hF1);
    mul(FN_TCMUL, FN_TCLAST, 4'hD, 4'hB, 8'h0F);
    complete_run();
  end
endmodule
